// File: sacr_regs.vh
`ifndef SACR_REGS_VH
`define SACR_REGS_VH

// Register address width and data width
`define SACR_AW 9
`define SACR_DW 16
`define SACR_NREG 9

// Register offsets
`define SACR_OFF_MUX_BIAS 9'h043
`define SACR_OFF_DRV_TRIM 9'h044
`define SACR_OFF_BIAS_SPARE 9'h046
`define SACR_OFF_CP_CTRL 9'h048
`define SACR_OFF_SPARE0 9'h050
`define SACR_OFF_SPARE1 9'h051
`define SACR_OFF_THERM_CTRL 9'h060
`define SACR_OFF_THERM_READ 9'h061
`define SACR_OFF_SER_PWR 9'h070
`define SACR_OFF_BLACK 9'h080

// Reset values
`define SACR_RST_MUX_BIAS 16'h0800
`define SACR_RST_DRV_TRIM 16'h0088
`define SACR_RST_BIAS_SPARE 16'h8888
`define SACR_RST_CP_CTRL 16'h1200
`define SACR_RST_SPARE0 16'h0000
`define SACR_RST_SPARE1 16'h8881
`define SACR_RST_THERM_CTRL 16'h0000
`define SACR_RST_THERM_READ 16'h0000
`define SACR_RST_SER_PWR 16'h0000
`define SACR_RST_BLACK 16'h4008

// Writable bit masks
`define SACR_MSK_MUX_BIAS 16'hff00
`define SACR_MSK_DRV_TRIM 16'h00ff
`define SACR_MSK_BIAS_SPARE 16'hffff
`define SACR_MSK_CP_CTRL 16'h7703
`define SACR_MSK_SPARE0 16'h03ff
`define SACR_MSK_SPARE1 16'hffff
`define SACR_MSK_THERM_CTRL 16'h0001
`define SACR_MSK_SER_PWR 16'h0007
`define SACR_MSK_BLACK 16'hffff

// Field positions
`define SACR_MUX_VCM_MSB 15
`define SACR_MUX_VCM_LSB 8
`define SACR_DRV_IBIAS_MSB 3
`define SACR_DRV_IBIAS_LSB 0
`define SACR_DRV_IREF_MSB 7
`define SACR_DRV_IREF_LSB 4
`define SACR_CP_XFER_EN_BIT 0
`define SACR_CP_FD_EN_BIT 1
`define SACR_CP_XFER_TRIM_MSB 10
`define SACR_CP_XFER_TRIM_LSB 8
`define SACR_CP_FD_TRIM_MSB 14
`define SACR_CP_FD_TRIM_LSB 12
`define SACR_THERM_EN_BIT 0
`define SACR_THERM_READ_MSB 7
`define SACR_THERM_READ_LSB 0
`define SACR_SER_CLK_BIT 0
`define SACR_SER_SYNC_BIT 1
`define SACR_SER_DATA_BIT 2
`define SACR_DATA_CHANNELS 4
`define SACR_BLACK_MSB 7
`define SACR_BLACK_LSB 0

`endif

// File: sacr_reg16.v
`timescale 1ns/10ps
`default_nettype none

// One 16-bit register with per-bit write mask
module sacr_reg16 #(
  parameter [15:0] RST_VAL = 16'h0000,
  parameter [15:0] WR_MASK = 16'hffff
) (
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [15:0] wdata_i,
  output wire [15:0] q_o
);

  reg [15:0] q_r;
  reg [15:0] q_nxt;

  always @* begin
    q_nxt = q_r;
    if (wr_i) begin
      q_nxt = (wdata_i & WR_MASK) | (q_r & ~WR_MASK);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule // sacr_reg16

`default_nettype wire

// File: sacr_regs_top.v
`timescale 1ns/10ps
`default_nettype none
`include "sacr_regs.vh"

module sacr_regs_top (
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire [8:0] ADDR_I,
  input wire WR_STB_I,
  input wire [15:0] WR_DATA_I,
  input wire RD_STB_I,
  input wire [7:0] TEMP_READOUT_I,
  output wire [15:0] RD_DATA_O,
  output wire RD_VALID_O,
  output wire ADDR_ERR_O,
  output wire [7:0] COLUMN_MUX_CM_BUFFER_BIAS_O,
  output wire [3:0] DRV_IBIAS_O,
  output wire [3:0] DRV_IREF_O,
  output wire [15:0] BIAS_SPARE_O,
  output wire XFER_PUMP_EN_O,
  output wire FD_PUMP_EN_O,
  output wire [2:0] XFER_PUMP_TRIM_O,
  output wire [2:0] FD_PUMP_TRIM_O,
  output wire [9:0] SPARE0_O,
  output wire [15:0] SPARE1_O,
  output wire THERM_DIODE_EN_O,
  output wire CLK_CH_PWR_UP_O,
  output wire SYNC_CH_PWR_UP_O,
  output wire [3:0] DATA_CH_PWR_UP_O,
  output wire [7:0] BLACK_TARGET_O,
  output wire [15:0] BLACK_SETUP_O
);

  localparam [3:0] IDX_MUX = 4'h0;
  localparam [3:0] IDX_DRV = 4'h1;
  localparam [3:0] IDX_BSP = 4'h2;
  localparam [3:0] IDX_CP = 4'h3;
  localparam [3:0] IDX_SP0 = 4'h4;
  localparam [3:0] IDX_SP1 = 4'h5;
  localparam [3:0] IDX_TEN = 4'h6;
  localparam [3:0] IDX_SER = 4'h7;
  localparam [3:0] IDX_BLK = 4'h8;

  // Full-width reset word of the readout register
  localparam [15:0] THERM_RST = `SACR_RST_THERM_READ;

  // Offset of each writable register
  function [8:0] reg_off;
    input integer idx;
    begin
      case (idx)
        0: reg_off = `SACR_OFF_MUX_BIAS;
        1: reg_off = `SACR_OFF_DRV_TRIM;
        2: reg_off = `SACR_OFF_BIAS_SPARE;
        3: reg_off = `SACR_OFF_CP_CTRL;
        4: reg_off = `SACR_OFF_SPARE0;
        5: reg_off = `SACR_OFF_SPARE1;
        6: reg_off = `SACR_OFF_THERM_CTRL;
        7: reg_off = `SACR_OFF_SER_PWR;
        8: reg_off = `SACR_OFF_BLACK;
        default: reg_off = `SACR_OFF_MUX_BIAS;
      endcase
    end
  endfunction

  // Reset value of each writable register
  function [15:0] reg_rst;
    input integer idx;
    begin
      case (idx)
        0: reg_rst = `SACR_RST_MUX_BIAS;
        1: reg_rst = `SACR_RST_DRV_TRIM;
        2: reg_rst = `SACR_RST_BIAS_SPARE;
        3: reg_rst = `SACR_RST_CP_CTRL;
        4: reg_rst = `SACR_RST_SPARE0;
        5: reg_rst = `SACR_RST_SPARE1;
        6: reg_rst = `SACR_RST_THERM_CTRL;
        7: reg_rst = `SACR_RST_SER_PWR;
        8: reg_rst = `SACR_RST_BLACK;
        default: reg_rst = 16'h0000;
      endcase
    end
  endfunction

  // Writable bits of each register
  function [15:0] reg_msk;
    input integer idx;
    begin
      case (idx)
        0: reg_msk = `SACR_MSK_MUX_BIAS;
        1: reg_msk = `SACR_MSK_DRV_TRIM;
        2: reg_msk = `SACR_MSK_BIAS_SPARE;
        3: reg_msk = `SACR_MSK_CP_CTRL;
        4: reg_msk = `SACR_MSK_SPARE0;
        5: reg_msk = `SACR_MSK_SPARE1;
        6: reg_msk = `SACR_MSK_THERM_CTRL;
        7: reg_msk = `SACR_MSK_SER_PWR;
        8: reg_msk = `SACR_MSK_BLACK;
        default: reg_msk = 16'h0000;
      endcase
    end
  endfunction

  wire [15:0] reg_q [0:`SACR_NREG-1];
  wire [`SACR_NREG-1:0] hit;
  wire [`SACR_NREG-1:0] wr_sel;
  wire therm_hit;
  wire any_hit;

  reg [7:0] therm_r;
  reg [7:0] therm_nxt;
  reg [15:0] rd_data_r;
  reg [15:0] rd_data_nxt;
  reg rd_valid_r;
  reg addr_err_r;
  reg addr_err_nxt;
  reg [15:0] rd_mux;
  integer k;

  // Register cells, decode per entry
  genvar gi;
  generate
    for (gi = 0; gi < `SACR_NREG; gi = gi + 1) begin : g_reg
      assign hit[gi] = (ADDR_I == reg_off(gi));
      assign wr_sel[gi] = WR_STB_I & hit[gi];
      sacr_reg16 #(
        .RST_VAL(reg_rst(gi)),
        .WR_MASK(reg_msk(gi))
      ) u_cell (
        .clk_i(REF_CLK_I),
        .rst_i(RESET_I),
        .wr_i(wr_sel[gi]),
        .wdata_i(WR_DATA_I),
        .q_o(reg_q[gi])
      );
    end
  endgenerate

  // Readout register decoded separately, never written
  assign therm_hit = (ADDR_I == `SACR_OFF_THERM_READ);
  assign any_hit = (|hit) | therm_hit;

  // Temperature capture while diode is on
  always @* begin
    therm_nxt = therm_r;
    if (reg_q[IDX_TEN][`SACR_THERM_EN_BIT]) begin
      therm_nxt = TEMP_READOUT_I;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      therm_r <= THERM_RST[7:0];
    end else begin
      therm_r <= therm_nxt;
    end
  end

  // Read multiplexer
  always @* begin
    rd_mux = 16'h0000;
    for (k = 0; k < `SACR_NREG; k = k + 1) begin
      if (hit[k]) begin
        rd_mux = reg_q[k];
      end
    end
    if (therm_hit) begin
      rd_mux = {8'h00, therm_r};
    end
  end

  // Read data and access error capture
  always @* begin
    rd_data_nxt = rd_data_r;
    addr_err_nxt = 1'b0;
    if (RD_STB_I) begin
      rd_data_nxt = rd_mux;
    end
    if ((RD_STB_I | WR_STB_I) & ~any_hit) begin
      addr_err_nxt = 1'b1;
    end
    if (WR_STB_I & therm_hit) begin
      addr_err_nxt = 1'b1;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
      addr_err_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= RD_STB_I;
      addr_err_r <= addr_err_nxt;
    end
  end

  assign RD_DATA_O = rd_data_r;
  assign RD_VALID_O = rd_valid_r;
  assign ADDR_ERR_O = addr_err_r;

  // Column mux bias field
  assign COLUMN_MUX_CM_BUFFER_BIAS_O =
    reg_q[IDX_MUX][`SACR_MUX_VCM_MSB:`SACR_MUX_VCM_LSB];

  // Output driver trims and bias spare word
  assign DRV_IBIAS_O = reg_q[IDX_DRV][`SACR_DRV_IBIAS_MSB:`SACR_DRV_IBIAS_LSB];
  assign DRV_IREF_O = reg_q[IDX_DRV][`SACR_DRV_IREF_MSB:`SACR_DRV_IREF_LSB];
  assign BIAS_SPARE_O = reg_q[IDX_BSP];

  // Charge pump enables and trims
  assign XFER_PUMP_EN_O = reg_q[IDX_CP][`SACR_CP_XFER_EN_BIT];
  assign FD_PUMP_EN_O = reg_q[IDX_CP][`SACR_CP_FD_EN_BIT];
  assign XFER_PUMP_TRIM_O =
    reg_q[IDX_CP][`SACR_CP_XFER_TRIM_MSB:`SACR_CP_XFER_TRIM_LSB];
  assign FD_PUMP_TRIM_O =
    reg_q[IDX_CP][`SACR_CP_FD_TRIM_MSB:`SACR_CP_FD_TRIM_LSB];

  // Spare words
  assign SPARE0_O = reg_q[IDX_SP0][9:0];
  assign SPARE1_O = reg_q[IDX_SP1];

  // Temperature diode enable
  assign THERM_DIODE_EN_O = reg_q[IDX_TEN][`SACR_THERM_EN_BIT];

  // Serializer channel power, active-high power-up control
  assign CLK_CH_PWR_UP_O = reg_q[IDX_SER][`SACR_SER_CLK_BIT];
  assign SYNC_CH_PWR_UP_O = reg_q[IDX_SER][`SACR_SER_SYNC_BIT];

  genvar gc;
  generate
    for (gc = 0; gc < `SACR_DATA_CHANNELS; gc = gc + 1) begin : g_dch
      assign DATA_CH_PWR_UP_O[gc] = reg_q[IDX_SER][`SACR_SER_DATA_BIT];
    end
  endgenerate

  // Black level target and full black setup word
  assign BLACK_TARGET_O = reg_q[IDX_BLK][`SACR_BLACK_MSB:`SACR_BLACK_LSB];
  assign BLACK_SETUP_O = reg_q[IDX_BLK];

endmodule // sacr_regs_top

`default_nettype wire

// File: sacr_host.sv
`timescale 1ns/10ps
`default_nettype none
module sacr_host (
  input wire logic clk_i,
  output logic [8:0] addr_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  output logic rd_o,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic err_i
);
  initial begin
    addr_o = 9'h000;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [8:0] a, input logic [15:0] d, output logic e);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    #1 e = err_i;
  endtask
  task automatic rd(input logic [8:0] a, output logic [15:0] d, output logic v, output logic e);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
    v = rvalid_i;
    e = err_i;
  endtask
endmodule // sacr_host
`default_nettype wire

// File: sacr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sacr_monitor (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic [8:0] ADDR_I,
  input wire logic WR_STB_I,
  input wire logic [15:0] WR_DATA_I,
  input wire logic RD_STB_I,
  input wire logic [15:0] RD_DATA_O,
  input wire logic RD_VALID_O,
  input wire logic [7:0] COLUMN_MUX_CM_BUFFER_BIAS_O,
  input wire logic [2:0] XFER_PUMP_TRIM_O,
  input wire logic THERM_DIODE_EN_O,
  input wire logic [3:0] DATA_CH_PWR_UP_O,
  input wire logic [15:0] BLACK_SETUP_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  a_mux_write: assert property (WR_STB_I && ADDR_I == 9'h043 |=>
    COLUMN_MUX_CM_BUFFER_BIAS_O == $past(WR_DATA_I[15:8])) else $error("mux bias");
  a_trim_write: assert property (WR_STB_I && ADDR_I == 9'h048 |=>
    XFER_PUMP_TRIM_O == $past(WR_DATA_I[10:8])) else $error("pump trim");
  a_diode_write: assert property (WR_STB_I && ADDR_I == 9'h060 |=>
    THERM_DIODE_EN_O == $past(WR_DATA_I[0])) else $error("diode enable");
  a_data_joint: assert property (WR_STB_I && ADDR_I == 9'h070 |=>
    DATA_CH_PWR_UP_O == {4{$past(WR_DATA_I[2])}}) else $error("data channels split");
  a_black_write: assert property (WR_STB_I && ADDR_I == 9'h080 |=>
    BLACK_SETUP_O == $past(WR_DATA_I)) else $error("black setup");
  a_reset_values: assert property ($past(RESET_I) |-> BLACK_SETUP_O == 16'h4008 &&
    XFER_PUMP_TRIM_O == 3'h2 && !THERM_DIODE_EN_O) else $error("reset value");
  a_temp_upper: assert property (RD_STB_I && ADDR_I == 9'h061 |=>
    RD_VALID_O && RD_DATA_O[15:8] == 8'h00) else $error("temp upper");
  a_valid_cause: assert property (RD_VALID_O |-> $past(RD_STB_I))
    else $error("stray valid");
  cover property (WR_STB_I && ADDR_I == 9'h070);
  cover property (RD_STB_I && ADDR_I == 9'h061);
  cover property (RD_VALID_O && RD_DATA_O[7:0] != 8'h00);
endmodule // sacr_monitor
bind sacr_regs_top sacr_monitor u_mon (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
  .ADDR_I(ADDR_I), .WR_STB_I(WR_STB_I), .WR_DATA_I(WR_DATA_I), .RD_STB_I(RD_STB_I),
  .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O),
  .COLUMN_MUX_CM_BUFFER_BIAS_O(COLUMN_MUX_CM_BUFFER_BIAS_O),
  .XFER_PUMP_TRIM_O(XFER_PUMP_TRIM_O), .THERM_DIODE_EN_O(THERM_DIODE_EN_O),
  .DATA_CH_PWR_UP_O(DATA_CH_PWR_UP_O), .BLACK_SETUP_O(BLACK_SETUP_O));
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] temp = 8'h5a;
  wire [8:0] addr;
  wire wr, rd, rv, er, cke, sye, xen, fen, ten;
  wire [15:0] wd, rdat, bsp, sp1, bset;
  wire [9:0] sp0;
  wire [7:0] bias, black;
  wire [2:0] xtrim, ftrim;
  wire [3:0] dch, ib, ir;
  logic [15:0] d;
  logic v, e;
  int mismatches = 0;
  int checked = 0;
  logic [63:0] rows [10] = '{64'h0043_0800_ffff_ff00, 64'h0044_0088_ffff_00ff,
    64'h0046_8888_1234_1234, 64'h0048_1200_ffff_7703, 64'h0050_0000_ffff_03ff,
    64'h0051_8881_4321_4321, 64'h0061_0000_ffff_0000, 64'h0060_0000_ffff_0001,
    64'h0070_0000_0007_0007, 64'h0080_4008_abcd_abcd};
  always #50 clk = ~clk;
  sacr_host u_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wd), .rd_o(rd),
    .rdata_i(rdat), .rvalid_i(rv), .err_i(er));
  sacr_regs_top u_dut (.REF_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WR_STB_I(wr),
    .WR_DATA_I(wd), .RD_STB_I(rd), .TEMP_READOUT_I(temp), .RD_DATA_O(rdat),
    .RD_VALID_O(rv), .ADDR_ERR_O(er), .COLUMN_MUX_CM_BUFFER_BIAS_O(bias),
    .DRV_IBIAS_O(ib), .DRV_IREF_O(ir), .BIAS_SPARE_O(bsp), .XFER_PUMP_EN_O(xen),
    .FD_PUMP_EN_O(fen), .XFER_PUMP_TRIM_O(xtrim), .FD_PUMP_TRIM_O(ftrim),
    .SPARE0_O(sp0), .SPARE1_O(sp1), .THERM_DIODE_EN_O(ten), .CLK_CH_PWR_UP_O(cke),
    .SYNC_CH_PWR_UP_O(sye), .DATA_CH_PWR_UP_O(dch), .BLACK_TARGET_O(black),
    .BLACK_SETUP_O(bset));
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({bias, black}, 16'h0808);
    chk({5'h0, xtrim, 1'b0, ftrim, dch}, 16'h0210);
    chk({ir, ib, 5'h0, xen, fen, ten}, 16'h8800);
    chk(bset, 16'h4008);
    chk(bsp, 16'h8888);
    chk(sp1, 16'h8881);
    chk({6'h0, sp0}, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      u_host.rd(rows[i][56:48], d, v, e);
      chk(d, rows[i][47:32]);
      u_host.wr(rows[i][56:48], rows[i][31:16], e);
      u_host.rd(rows[i][56:48], d, v, e);
      chk(d, rows[i][15:0]);
      chk({15'h0, v}, 16'h0001);
    end
    $display("table test done");
    chk({bias, black}, 16'hffcd);
    chk({cke, sye, 10'h0, dch}, 16'hc00f);
    chk({ir, ib, 5'h0, xen, fen, ten}, 16'hff07);
    chk(bset, 16'habcd);
    chk(bsp, 16'h1234);
    chk(sp1, 16'h4321);
    chk({6'h0, sp0}, 16'h03ff);
    u_host.wr(9'h070, 16'h0004, e);
    chk({cke, sye, 10'h0, dch}, 16'h000f);
    u_host.rd(9'h061, d, v, e);
    chk(d, 16'h005a);
    chk({15'h0, v}, 16'h0001);
    @(posedge clk);
    #1 chk({15'h0, rv}, 16'h0000);
    u_host.wr(9'h061, 16'h1234, e);
    chk({15'h0, e}, 16'h0001);
    u_host.rd(9'h061, d, v, e);
    chk({e, d[14:0]}, 16'h005a);
    u_host.rd(9'h1ff, d, v, e);
    chk({e, d[14:0]}, 16'h8000);
    @(posedge clk);
    temp <= 8'hc3;
    u_host.wr(9'h060, 16'h0000, e);
    @(posedge clk);
    temp <= 8'h11;
    u_host.rd(9'h061, d, v, e);
    chk(d, 16'h00c3);
    chk({15'h0, ten}, 16'h0000);
    $display("edge test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({black, 4'h0, dch}, 16'h0800);
    chk({ir, ib, 5'h0, xen, fen, ten}, 16'h8800);
    chk({5'h0, xtrim, 1'b0, ftrim, 4'h0}, 16'h0210);
    chk({cke, sye, 14'h0}, 16'h0000);
    $display("second reset test done");
    final_report;
  end
endmodule // tb_top
`default_nettype wire
